// ---- inc/rplm_freq_if.sv ----
/*
 * Carrier between the register bank and one frequency meter.
 * Assumes edge_seen is a one-cycle pulse on the core clock.
 */
interface rplm_freq_if;
   import rplm_pkg::*;
   logic              edge_seen;
   logic [FREQ_W-1:0] count;
   logic              stable;
   modport meter (input edge_seen, output count, output stable);
   modport user  (output edge_seen, input count, input stable);
endinterface

// ---- inc/rplm_pkg.sv ----
/*
 * Constants and types of the receive-port link monitor register bank.
 * Assumes a 10 MHz core clock and a byte-wide local register port.
 */
package rplm_pkg;

   // Widths fixed by the bank layout
   localparam int NUM_PORTS  = 2;
   localparam int FREQ_W     = 16;
   localparam int PAR_W      = 16;

   // Register offsets
   localparam logic [7:0] ADDR_GEN_CFG   = 8'h02;
   localparam logic [7:0] ADDR_PORT_SEL  = 8'h4C;
   localparam logic [7:0] ADDR_PORT_STS1 = 8'h4D;
   localparam logic [7:0] ADDR_PORT_STS2 = 8'h4E;
   localparam logic [7:0] ADDR_FREQ_INT  = 8'h4F;
   localparam logic [7:0] ADDR_FREQ_FRAC = 8'h50;
   localparam logic [7:0] ADDR_ALARM     = 8'h51;
   localparam logic [7:0] ADDR_VOLT      = 8'h52;
   localparam logic [7:0] ADDR_TEMP      = 8'h53;
   localparam logic [7:0] ADDR_PIXERR    = 8'h54;
   localparam logic [7:0] ADDR_PAR_HI    = 8'h55;
   localparam logic [7:0] ADDR_PAR_LO    = 8'h56;
   localparam logic [7:0] ADDR_THR_HI    = 8'hC0;
   localparam logic [7:0] ADDR_THR_LO    = 8'hC1;

   // Field positions
   localparam int GEN_CFG_PAR_EN_BIT = 4;
   localparam int PORT_SEL_BIT       = 0;
   localparam int STS1_PORT_NUM_BIT  = 6;
   localparam int STS1_PAR_FLAG_BIT  = 2;
   localparam int STS2_FREQ_STB_BIT  = 2;

   // Valid bits of the mirrored sensor bytes; reserved bits read zero
   localparam logic [7:0] ALARM_MASK  = 8'h3F;
   localparam logic [7:0] VOLT_MASK   = 8'h77;
   localparam logic [7:0] TEMP_MASK   = 8'h07;
   localparam logic [7:0] PIXERR_MASK = 8'h1F;

   // Reset values
   localparam logic [7:0]       GEN_CFG_RESET  = 8'h10;
   localparam logic [7:0]       SENSOR_RESET   = 8'h00;
   localparam logic [PAR_W-1:0] THR_RESET      = 16'h00FF;
   localparam logic [FREQ_W-1:0] FREQ_RESET    = 16'h0000;

   // Gate of 256 us: edge count equals frequency in 1/256 MHz
   localparam int CLK_PERIOD_NS = 100;
   localparam int GATE_TIME_NS  = 256000;
   localparam int GATE_CYCLES   = GATE_TIME_NS / CLK_PERIOD_NS;
   localparam int GATE_W        = 12;

   typedef logic [7:0] rplm_byte_type;
   typedef logic [3:0][7:0] rplm_sensor_type;

   typedef enum logic [0:0] {
      SNAP_IDLE = 1'b0,
      SNAP_HELD = 1'b1
   } rplm_snap_state_type;

endpackage

// ---- rtl/rplm_freq_meter.sv ----
/*
 * Gated edge counter for one receive port's link reference.
 * Assumes the edge pulses come from a synchronised pin on clk.
 */
module rplm_freq_meter
   import rplm_pkg::*;
(
   input wire logic  clk,
   input wire logic  resetn,
   rplm_freq_if.meter fif
);

   logic [GATE_W-1:0] gate_cnt_ff;
   logic [FREQ_W-1:0] edge_cnt_ff;
   logic [FREQ_W-1:0] count_ff;
   logic              stable_ff;
   logic              gate_end;

   assign gate_end = (gate_cnt_ff == GATE_W'(GATE_CYCLES - 1));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gate_cnt_ff <= '0;
      end else if (gate_end) begin
         gate_cnt_ff <= '0;
      end else begin
         gate_cnt_ff <= gate_cnt_ff + GATE_W'(1);
      end
   end

   // Saturate so a fast input never wraps to a small reading
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         edge_cnt_ff <= '0;
      end else if (gate_end) begin
         edge_cnt_ff <= FREQ_W'(fif.edge_seen);
      end else if (fif.edge_seen && (edge_cnt_ff != '1)) begin
         edge_cnt_ff <= edge_cnt_ff + FREQ_W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_ff  <= FREQ_RESET;
         stable_ff <= 1'b0;
      end else if (gate_end) begin
         count_ff  <= edge_cnt_ff;
         stable_ff <= (edge_cnt_ff == count_ff);
      end
   end

   assign fif.count  = count_ff;
   assign fif.stable = stable_ff;

endmodule // rplm_freq_meter

// ---- rtl/rplm_top.sv ----
/*
 * Per-port link monitor register bank: frequency reading, mirrored
 * remote sensor status and a clear-on-read parity error counter.
 * Assumes a byte register port from the host-side serial target on clk,
 * and forward-channel, lock and parity pulses on clk.
 */

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - each port keeps its own bank; port select steers host access.
// - whole-MHz part of measured link frequency is a read-only byte.
// - fraction in 1/256 MHz is a read-only byte, zero after reset.
// - four sensor bytes load from forward channel, never from host writes.
// - alarm byte holds six remote alarm flags in bits 5 to 0.
// - voltage byte holds two 3-bit samples, bits 7 and 3 zero.
// - temperature byte holds a 3-bit sample, upper bits zero.
// - pixel-interface byte holds five remote error flags in bits 4 to 0.
// - parity errors counted; restart on valid lock and low-byte read.
// - sixteen-bit count split into upper and lower byte registers.
// - upper byte clears when the lower byte is read.
// - reading the lower byte clears it.
// - port parity flag rises above threshold, drops when count cleared.
module rplm_top
   import rplm_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              resetn,
   input  wire logic [7:0]                        reg_addr,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   input  wire logic [7:0]                        reg_wdata,
   output      logic [7:0]                        reg_rdata_ff,
   input  wire logic [NUM_PORTS-1:0]              link_clk_pin,
   input  wire logic [NUM_PORTS-1:0]              lock_valid,
   input  wire logic [NUM_PORTS-1:0]              par_err,
   input  wire logic [NUM_PORTS-1:0]              fc_load,
   input  wire logic [NUM_PORTS-1:0][31:0]        fc_sensor,
   output      logic [NUM_PORTS-1:0]              par_flag_ff,
   output      logic                              par_check_en_ff
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   logic [NUM_PORTS-1:0]             sync1_ff;
   logic [NUM_PORTS-1:0]             sync2_ff;
   logic [NUM_PORTS-1:0]             sync3_ff;
   logic [NUM_PORTS-1:0][FREQ_W-1:0] freq_count;
   logic [NUM_PORTS-1:0]             freq_stable;

   logic                             port_sel_ff;
   logic [7:0]                       gen_cfg_ff;

   rplm_sensor_type                  sensor_ff   [NUM_PORTS];
   logic [PAR_W-1:0]                 par_cnt_ff  [NUM_PORTS];
   logic [PAR_W-1:0]                 nxt_par_cnt [NUM_PORTS];
   logic [7:0]                       snap_lo_ff  [NUM_PORTS];
   rplm_snap_state_type              snap_st_ff  [NUM_PORTS];
   logic [PAR_W-1:0]                 thr_ff      [NUM_PORTS];

   logic [NUM_PORTS-1:0]             rd_hi;
   logic [NUM_PORTS-1:0]             rd_lo;
   logic [NUM_PORTS-1:0]             wr_thr_hi;
   logic [NUM_PORTS-1:0]             wr_thr_lo;
   logic [NUM_PORTS-1:0]             par_clear;
   logic [7:0]                       nxt_rdata;

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Keeps only the documented bits of a mirrored sensor byte
   function automatic rplm_byte_type sensor_mask(input int idx, input rplm_byte_type raw);
      rplm_byte_type m;
      m = 8'h00;
      unique case (idx)
         0: m = ALARM_MASK;
         1: m = VOLT_MASK;
         2: m = TEMP_MASK;
         3: m = PIXERR_MASK;
         default: m = 8'h00;
      endcase
      return raw & m;
   endfunction

   function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Link reference synchroniser and frequency meters

   // Third stage only feeds the edge detector, never the first stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end else begin
         sync1_ff <= link_clk_pin;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_meter
      rplm_freq_if fif ();

      assign fif.edge_seen  = sync2_ff[p] & ~sync3_ff[p];
      assign freq_count[p]  = fif.count;
      assign freq_stable[p] = fif.stable;

      rplm_freq_meter rplm_freq_meter_inst (
         .clk    (clk),
         .resetn (resetn),
         .fif    (fif.meter)
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Global configuration: port select and parity checker enable

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_sel_ff <= 1'b0;
      end else if (reg_wr && hits(reg_addr, ADDR_PORT_SEL)) begin
         port_sel_ff <= reg_wdata[PORT_SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gen_cfg_ff <= GEN_CFG_RESET;
      end else if (reg_wr && hits(reg_addr, ADDR_GEN_CFG)) begin
         gen_cfg_ff <= reg_wdata;
      end
   end

   // Checker enable leaves the block; host clears it before reading count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         par_check_en_ff <= GEN_CFG_RESET[GEN_CFG_PAR_EN_BIT];
      end else if (reg_wr && hits(reg_addr, ADDR_GEN_CFG)) begin
         par_check_en_ff <= reg_wdata[GEN_CFG_PAR_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Per-port access strobes

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         rd_hi[p]     = reg_rd && (port_sel_ff == p[0]) && hits(reg_addr, ADDR_PAR_HI);
         rd_lo[p]     = reg_rd && (port_sel_ff == p[0]) && hits(reg_addr, ADDR_PAR_LO);
         wr_thr_hi[p] = reg_wr && (port_sel_ff == p[0]) && hits(reg_addr, ADDR_THR_HI);
         wr_thr_lo[p] = reg_wr && (port_sel_ff == p[0]) && hits(reg_addr, ADDR_THR_LO);
         par_clear[p] = rd_lo[p] || lock_valid[p];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mirrored remote sensor status

   // Host writes never reach these bytes; only the forward channel loads
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            sensor_ff[p] <= {4{SENSOR_RESET}};
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (fc_load[p]) begin
               for (int i = 0; i < 4; i++) begin
                  sensor_ff[p][i] <= sensor_mask(i, fc_sensor[p][i*8 +: 8]);
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Parity error counter

   // An error in the clearing cycle survives as a count of one
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (par_clear[p]) begin
            nxt_par_cnt[p] = PAR_W'(par_err[p] && par_check_en_ff);
         end else if (par_err[p] && par_check_en_ff && (par_cnt_ff[p] != '1)) begin
            nxt_par_cnt[p] = par_cnt_ff[p] + PAR_W'(1);
         end else begin
            nxt_par_cnt[p] = par_cnt_ff[p];
         end
      end
   end

   // Both bytes clear together on a low read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            par_cnt_ff[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            par_cnt_ff[p] <= nxt_par_cnt[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Coherent capture of the low byte

   // Upper read freezes the low byte so a later low read matches it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            snap_st_ff[p] <= SNAP_IDLE;
            snap_lo_ff[p] <= 8'h00;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            unique case (snap_st_ff[p])
               SNAP_IDLE: begin
                  if (rd_hi[p]) begin
                     snap_st_ff[p] <= SNAP_HELD;
                     snap_lo_ff[p] <= par_cnt_ff[p][7:0];
                  end
               end
               SNAP_HELD: begin
                  if (par_clear[p]) begin
                     snap_st_ff[p] <= SNAP_IDLE;
                  end else if (rd_hi[p]) begin
                     snap_lo_ff[p] <= par_cnt_ff[p][7:0];
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Threshold and parity flag

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            thr_ff[p] <= THR_RESET;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_thr_hi[p]) begin
               thr_ff[p][15:8] <= reg_wdata;
            end
            if (wr_thr_lo[p]) begin
               thr_ff[p][7:0] <= reg_wdata;
            end
         end
      end
   end

   // Sticky until the count itself is cleared
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         par_flag_ff <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (par_clear[p]) begin
               par_flag_ff[p] <= 1'b0;
            end else if (par_cnt_ff[p] > thr_ff[p]) begin
               par_flag_ff[p] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      logic p;
      p         = port_sel_ff;
      nxt_rdata = 8'h00;
      unique case (reg_addr)
         ADDR_GEN_CFG: begin
            nxt_rdata = gen_cfg_ff;
         end
         ADDR_PORT_SEL: begin
            nxt_rdata = {7'h00, port_sel_ff};
         end
         ADDR_PORT_STS1: begin
            nxt_rdata[STS1_PORT_NUM_BIT] = p;
            nxt_rdata[STS1_PAR_FLAG_BIT] = par_flag_ff[p];
         end
         ADDR_PORT_STS2: begin
            nxt_rdata[STS2_FREQ_STB_BIT] = freq_stable[p];
         end
         ADDR_FREQ_INT: begin
            nxt_rdata = freq_count[p][15:8];
         end
         ADDR_FREQ_FRAC: begin
            nxt_rdata = freq_count[p][7:0];
         end
         ADDR_ALARM: begin
            nxt_rdata = sensor_ff[p][0];
         end
         ADDR_VOLT: begin
            nxt_rdata = sensor_ff[p][1];
         end
         ADDR_TEMP: begin
            nxt_rdata = sensor_ff[p][2];
         end
         ADDR_PIXERR: begin
            nxt_rdata = sensor_ff[p][3];
         end
         ADDR_PAR_HI: begin
            nxt_rdata = par_cnt_ff[p][15:8];
         end
         ADDR_PAR_LO: begin
            if (snap_st_ff[p] == SNAP_HELD) begin
               nxt_rdata = snap_lo_ff[p];
            end else begin
               nxt_rdata = par_cnt_ff[p][7:0];
            end
         end
         ADDR_THR_HI: begin
            nxt_rdata = thr_ff[p][15:8];
         end
         ADDR_THR_LO: begin
            nxt_rdata = thr_ff[p][7:0];
         end
         default: begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // Holds the last answer between reads
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

endmodule // rplm_top

// ---- testbench/rplm_props.sv ----
/*
 * Port checker for the link monitor register bank.
 * Assumes a bind to rplm_top and parity thresholds held at 1 or more.
 */
module rplm_props
   import rplm_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic [7:0]           reg_addr,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_wdata,
   input wire logic [7:0]           reg_rdata_ff,
   input wire logic [NUM_PORTS-1:0] lock_valid,
   input wire logic [NUM_PORTS-1:0] par_err,
   input wire logic [NUM_PORTS-1:0] fc_load,
   input wire logic [NUM_PORTS-1:0] par_flag_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sel_ff;
   logic rd_lo;

   // Own copy of the port select, so checks know the steered port
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sel_ff <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_PORT_SEL) begin
         sel_ff <= reg_wdata[PORT_SEL_BIT];
      end
   end

   assign rd_lo = reg_rd && reg_addr == ADDR_PAR_LO;

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////
   property p_alarm_rsv;
      reg_rd && reg_addr == ADDR_ALARM |=> reg_rdata_ff[7:6] == 2'b00;
   endproperty
   a_alarm_rsv: assert property (p_alarm_rsv)
      else $error("alarm byte reserved bits set");
   property p_volt_rsv;
      reg_rd && reg_addr == ADDR_VOLT |=> !reg_rdata_ff[7] && !reg_rdata_ff[3];
   endproperty
   a_volt_rsv: assert property (p_volt_rsv)
      else $error("voltage byte reserved bits set");
   property p_temp_rsv;
      reg_rd && reg_addr == ADDR_TEMP |=> reg_rdata_ff[7:3] == 5'h00;
   endproperty
   a_temp_rsv: assert property (p_temp_rsv)
      else $error("temperature byte reserved bits set");
   property p_pix_rsv;
      reg_rd && reg_addr == ADDR_PIXERR |=> reg_rdata_ff[7:5] == 3'h0;
   endproperty
   a_pix_rsv: assert property (p_pix_rsv)
      else $error("pixel error byte reserved bits set");
   property p_lo_clear;
      rd_lo && !par_err[sel_ff] ##1 rd_lo |=> reg_rdata_ff == 8'h00;
   endproperty
   a_lo_clear: assert property (p_lo_clear)
      else $error("lower count not cleared by read");
   property p_flag_drop;
      rd_lo |=> !par_flag_ff[$past(sel_ff)];
   endproperty
   a_flag_drop: assert property (p_flag_drop)
      else $error("parity flag kept after clear");
   property p_lock_drop;
      lock_valid[0] |=> !par_flag_ff[0];
   endproperty
   a_lock_drop: assert property (p_lock_drop)
      else $error("parity flag kept after lock");
   property p_sel_sts;
      reg_rd && reg_addr == ADDR_PORT_STS1 |=>
         reg_rdata_ff[STS1_PORT_NUM_BIT] == $past(sel_ff);
   endproperty
   a_sel_sts: assert property (p_sel_sts)
      else $error("status shows wrong port");
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata_ff);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without read");

   c_pair: cover property (reg_rd && reg_addr == ADDR_PAR_HI ##[1:8] rd_lo);
   c_flag: cover property ($rose(par_flag_ff[0]));
   c_load: cover property (fc_load[1]);
endmodule // rplm_props

bind rplm_top rplm_props rplm_props_inst (
   .clk          (clk),
   .resetn       (resetn),
   .reg_addr     (reg_addr),
   .reg_wr       (reg_wr),
   .reg_rd       (reg_rd),
   .reg_wdata    (reg_wdata),
   .reg_rdata_ff (reg_rdata_ff),
   .lock_valid   (lock_valid),
   .par_err      (par_err),
   .fc_load      (fc_load),
   .par_flag_ff  (par_flag_ff)
);

// ---- testbench/rplm_serializer_model.sv ----
/*
 * Remote serializer and receiver front end seen by the bank.
 * Assumes tasks are called by the bench at either clk edge.
 */
module rplm_serializer_model
   import rplm_pkg::*;
(
   input  wire logic                        clk,
   output      logic [NUM_PORTS-1:0]        link_clk_pin,
   output      logic [NUM_PORTS-1:0]        lock_valid,
   output      logic [NUM_PORTS-1:0]        par_err,
   output      logic [NUM_PORTS-1:0]        fc_load,
   output      logic [NUM_PORTS-1:0][31:0]  fc_sensor
);
   timeunit 1ns;
   timeprecision 1ns;
   int                   half_ns [NUM_PORTS] = '{500, 800};
   logic [NUM_PORTS-1:0] run = '0;

   initial begin
      link_clk_pin = '0;
      lock_valid   = '0;
      par_err      = '0;
      fc_load      = '0;
      fc_sensor    = '0;
   end

   // References 1 MHz and 0.625 MHz, toggling on falling clk edges
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_ref
      always begin
         #(half_ns[p]);
         link_clk_pin[p] = run[p] ? ~link_clk_pin[p] : 1'b0;
      end
   end

   task automatic start_refs;
      run = '1;
   endtask

   task automatic send_status(input int p, input logic [31:0] w);
      @(posedge clk);
      fc_load[p]   <= 1'b1;
      fc_sensor[p] <= w;
      @(posedge clk);
      fc_load[p]   <= 1'b0;
      fc_sensor[p] <= ~w; // Idle lines must not repeat the sample
   endtask

   task automatic send_errs(input int p, input int n);
      repeat (n) begin
         @(posedge clk);
         par_err[p] <= 1'b1;
      end
      @(posedge clk);
      par_err[p] <= 1'b0;
   endtask

   task automatic send_lock(input int p);
      @(posedge clk);
      lock_valid[p] <= 1'b1;
      @(posedge clk);
      lock_valid[p] <= 1'b0;
   endtask
endmodule // rplm_serializer_model

// ---- testbench/rplm_tb_top.sv ----
/*
 * Self-checking bench for the link monitor register bank.
 * Assumes the serializer model drives all link-side inputs.
 */
module rplm_tb_top
   import rplm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic                       clk = 1'b0;
   logic                       resetn;
   logic                       reg_wr;
   logic                       reg_rd;
   logic [7:0]                 reg_addr;
   logic [7:0]                 reg_wdata;
   logic [7:0]                 reg_rdata_ff;
   logic [NUM_PORTS-1:0]       link_clk_pin;
   logic [NUM_PORTS-1:0]       lock_valid;
   logic [NUM_PORTS-1:0]       par_err;
   logic [NUM_PORTS-1:0]       fc_load;
   logic [NUM_PORTS-1:0][31:0] fc_sensor;
   logic [NUM_PORTS-1:0]       par_flag_ff;
   logic                       par_check_en_ff;
   logic [7:0]                 b;
   int                         bad_count = 0;
   int                         cmp_count = 0;

   always #50 clk = ~clk;

   rplm_top rplm_top_inst (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .link_clk_pin(link_clk_pin), .lock_valid(lock_valid), .par_err(par_err),
      .fc_load(fc_load), .fc_sensor(fc_sensor), .par_flag_ff(par_flag_ff),
      .par_check_en_ff(par_check_en_ff)
   );

   rplm_serializer_model rplm_serializer_model_inst (
      .clk(clk), .link_clk_pin(link_clk_pin), .lock_valid(lock_valid),
      .par_err(par_err), .fc_load(fc_load), .fc_sensor(fc_sensor)
   );

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Outputs launched by the write edge are only settled here
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata_ff & m, e);
   endtask

   task automatic print_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      #3_000_000;
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      resetn    = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rplm_serializer_model_inst.start_refs();
      rd(ADDR_FREQ_FRAC, 8'h00);
      for (logic [7:0] a = 8'h51; a < 8'h57; a++) rd(a, 8'h00);
      rd(8'h57, 8'h00);
      rd(ADDR_GEN_CFG, 8'h10);
      // Walk one bit through every flag and sample field
      for (int i = 0; i < 8; i++) begin
         b = 8'h01 << i;
         rplm_serializer_model_inst.send_status(0, {4{b}});
         rd(ADDR_ALARM, b & 8'h3F);
         rd(ADDR_VOLT, b & 8'h77);
         rd(ADDR_TEMP, b & 8'h07);
         rd(ADDR_PIXERR, b & 8'h1F);
      end
      rplm_serializer_model_inst.send_status(0, 32'h0A05_212A);
      rplm_serializer_model_inst.send_status(1, 32'h1111_1111);
      wr(ADDR_ALARM, 8'h15);
      rd(ADDR_ALARM, 8'h2A);
      rd(ADDR_PORT_STS1, 8'h00, 8'h40);
      wr(ADDR_PORT_SEL, 8'h01);
      rd(ADDR_PORT_STS1, 8'h40, 8'h40);
      rd(ADDR_ALARM, 8'h11);
      // Port 1 count 2, then threshold lowered under it
      rplm_serializer_model_inst.send_errs(1, 2);
      @(negedge clk);
      chk({7'h00, par_flag_ff[1]}, 8'h00);
      wr(ADDR_THR_HI, 8'h00);
      wr(ADDR_THR_LO, 8'h01);
      repeat (2) @(negedge clk);
      chk({7'h00, par_flag_ff[1]}, 8'h01);
      wr(ADDR_PORT_SEL, 8'h00);
      rplm_serializer_model_inst.send_errs(0, 'h1FF);
      repeat (2) @(negedge clk);
      chk({7'h00, par_flag_ff[0]}, 8'h01);
      rd(ADDR_PAR_HI, 8'h01);
      rd(ADDR_PAR_HI, 8'h01);
      // An error between the two halves must not tear the value
      rplm_serializer_model_inst.send_errs(0, 1);
      rd(ADDR_PAR_LO, 8'hFF);
      chk({7'h00, par_flag_ff[0]}, 8'h00);
      rd(ADDR_PAR_HI, 8'h00);
      rd(ADDR_PAR_LO, 8'h00);
      wr(ADDR_GEN_CFG, 8'h00);
      chk({7'h00, par_check_en_ff}, 8'h00);
      rplm_serializer_model_inst.send_errs(0, 5);
      rd(ADDR_PAR_LO, 8'h00);
      wr(ADDR_GEN_CFG, 8'h10);
      rplm_serializer_model_inst.send_errs(0, 4);
      rplm_serializer_model_inst.send_lock(0);
      rd(ADDR_PAR_LO, 8'h00);
      rplm_serializer_model_inst.send_errs(0, 7);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= ADDR_PAR_LO;
      @(posedge clk);
      @(negedge clk);
      chk(reg_rdata_ff, 8'h07);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk(reg_rdata_ff, 8'h00);
      wr(ADDR_PORT_SEL, 8'h01);
      rd(ADDR_PAR_LO, 8'h02);
      // Several full gates so both readings settle
      repeat (3 * GATE_CYCLES) @(posedge clk);
      rd(ADDR_FREQ_INT, 8'h00);
      rd(ADDR_FREQ_FRAC, 8'hA0);
      rd(ADDR_PORT_STS2, 8'h04, 8'h04);
      wr(ADDR_PORT_SEL, 8'h00);
      rd(ADDR_FREQ_INT, 8'h01);
      rd(ADDR_FREQ_FRAC, 8'h00);
      print_verdict();
   end
endmodule // rplm_tb_top
